// ---- design/etc_pkg.sv ----
package etc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_RESULT   = 8'h08;
    localparam logic [7:0] ADDR_INT_STAT = 8'h0C;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;

    // ------------------------------------------------------------
    // capture modes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_OFF      = 3'h0;
    localparam logic [2:0] MODE_FALL     = 3'h1;
    localparam logic [2:0] MODE_RISE     = 3'h2;
    localparam logic [2:0] MODE_BOTH     = 3'h3;
    localparam logic [2:0] MODE_FIRST    = 3'h4;
    localparam logic [2:0] MODE_DIV4     = 3'h5;
    localparam logic [2:0] MODE_DIV16    = 3'h6;

    // ------------------------------------------------------------
    // sizes, counts and reset values
    // ------------------------------------------------------------
    localparam int         FIFO_DEPTH    = 4;
    localparam logic [2:0] FIFO_FULL     = 3'h4;
    localparam logic [3:0] DIV4_LAST     = 4'h3;
    localparam logic [3:0] DIV16_LAST    = 4'hF;
    localparam int         CTRL_W        = 9;
    localparam int         INT_W         = 3;
    localparam logic [INT_W-1:0] INT_RESET = 3'h0;

    // interrupt status / mask bit positions
    localparam int         INT_FILL      = 0;
    localparam int         INT_CAPT      = 1;
    localparam int         INT_OVFL      = 2;

    // status register bit positions
    localparam int         STAT_NEMPTY   = 0;
    localparam int         STAT_OVFL     = 1;
    localparam int         STAT_CNT_LO   = 2;

    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // control word: bits [2:0] mode, 3 first edge rising, 4 second base,
    // 5 joined 32-bit base, [7:6] fill level minus one, 8 enable
    typedef struct packed {
        logic       enable;
        logic [1:0] fill_sel;
        logic       wide32;
        logic       src_second;
        logic       first_rising;
        logic [2:0] mode;
    } etc_ctrl_type;

    localparam etc_ctrl_type CTRL_RESET = '{enable: 1'b0, fill_sel: 2'h0, wide32: 1'b0,
                                           src_second: 1'b0, first_rising: 1'b0, mode: 3'h0};

endpackage

// ---- design/etc_top.sv ----
`timescale 1ns/1ps

// Contract
// - latch selected base, 16 or 32 bits
// - falling mode: capture every falling edge only
// - rising mode: capture every rising edge
// - every-edge mode captures both directions
// - every-edge after chosen first edge polarity
// - divide-by-four: capture every fourth rising edge
// - divide-by-sixteen: every sixteenth rising edge
// - software selects either 16-bit time base
// - 32-bit mode captures both bases joined
// - four-entry first-in first-out result buffer
// - interrupt at one to four filled entries
// - capture event wakes from sleep or idle
// - capture event offered as external interrupt
module etc_top (
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic        capture_input_pin_in,
    input  wire logic [15:0] first_time_base_in,
    input  wire logic [15:0] second_time_base_in,
    input  wire logic        cpu_low_power_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic             irq_out,
    output logic             wake_out,
    output logic             ext_event_out
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    etc_pkg::etc_ctrl_type    ctrl_r;
    logic [etc_pkg::INT_W-1:0] int_stat_r;
    logic [etc_pkg::INT_W-1:0] int_mask_r;
    logic [etc_pkg::INT_W-1:0] int_set;
    logic [7:0]               aw_addr_r;
    logic [31:0]              w_data_r;
    logic [3:0]               w_strb_r;
    logic                     aw_hold_r;
    logic                     w_hold_r;
    logic                     wr_do;
    logic                     rd_take;
    logic                     pin_s1_r;
    logic                     pin_s2_r;
    logic                     pin_s3_r;
    logic                     rise;
    logic                     fall;
    logic                     cap_evt;
    logic                     armed_r;
    logic [3:0]               pres_r;
    logic                     restart;
    logic [31:0]              cap_value;
    logic [31:0]              fifo_mem [etc_pkg::FIFO_DEPTH];
    logic [1:0]               wr_ptr_r;
    logic [1:0]               rd_ptr_r;
    logic [2:0]               count_r;
    logic [2:0]               count_nxt;
    logic [2:0]               fill_level;
    logic                     push;
    logic                     pop;
    logic                     ovfl_evt;
    logic                     ovfl_r;
    logic [31:0]              rd_word;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    // address and data are held until the response is taken, so a
    // second write cannot overtake the first one
    assign wr_do = aw_hold_r && w_hold_r && !s_axi_bvalid_out;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            aw_hold_r         <= 1'b0;
            w_hold_r          <= 1'b0;
            aw_addr_r         <= 8'h00;
            w_data_r          <= 32'h00000000;
            w_strb_r          <= 4'h0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= etc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_hold_r         <= 1'b1;
                aw_addr_r         <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_hold_r         <= 1'b1;
                w_data_r         <= s_axi_wdata_in;
                w_strb_r         <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid_out <= 1'b1;
                case (aw_addr_r)
                    etc_pkg::ADDR_CTRL, etc_pkg::ADDR_STATUS, etc_pkg::ADDR_RESULT,
                    etc_pkg::ADDR_INT_STAT, etc_pkg::ADDR_INT_MASK: begin
                        s_axi_bresp_out <= etc_pkg::RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp_out <= etc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out  <= 1'b0;
                aw_hold_r         <= 1'b0;
                w_hold_r          <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // control and mask registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_r     <= etc_pkg::CTRL_RESET;
            int_mask_r <= etc_pkg::INT_RESET;
        end else if (wr_do) begin
            if (aw_addr_r == etc_pkg::ADDR_CTRL) begin
                if (w_strb_r[0]) begin
                    ctrl_r[7:0] <= w_data_r[7:0];
                end
                if (w_strb_r[1]) begin
                    ctrl_r.enable <= w_data_r[8];
                end
            end
            if (aw_addr_r == etc_pkg::ADDR_INT_MASK && w_strb_r[0]) begin
                int_mask_r <= w_data_r[etc_pkg::INT_W-1:0];
            end
        end
    end

    // any write of the control word restarts edge arming and prescaling
    assign restart = (wr_do && aw_addr_r == etc_pkg::ADDR_CTRL) || !ctrl_r.enable;

    // ------------------------------------------------------------
    // input synchroniser and edge detection
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
        end else begin
            pin_s1_r <= capture_input_pin_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // edges from stages two and three, never stage one
    assign rise = pin_s2_r && !pin_s3_r;
    assign fall = !pin_s2_r && pin_s3_r;

    // ------------------------------------------------------------
    // capture event selection
    // ------------------------------------------------------------
    always_comb begin
        cap_evt = 1'b0;
        if (ctrl_r.enable) begin
            case (ctrl_r.mode)
                etc_pkg::MODE_FALL: cap_evt = fall;
                etc_pkg::MODE_RISE: cap_evt = rise;
                etc_pkg::MODE_BOTH: cap_evt = rise || fall;
                etc_pkg::MODE_FIRST: begin
                    if (armed_r) begin
                        cap_evt = rise || fall;
                    end else begin
                        cap_evt = ctrl_r.first_rising ? rise : fall;
                    end
                end
                etc_pkg::MODE_DIV4: cap_evt = rise && (pres_r == etc_pkg::DIV4_LAST);
                etc_pkg::MODE_DIV16: cap_evt = rise && (pres_r == etc_pkg::DIV16_LAST);
                default: cap_evt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            armed_r <= 1'b0;
        end else if (restart) begin
            armed_r <= 1'b0;
        end else if (ctrl_r.mode == etc_pkg::MODE_FIRST && cap_evt) begin
            armed_r <= 1'b1;
        end
    end

    // prescaler counts rising edges and wraps at the capture edge
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pres_r <= 4'h0;
        end else if (restart) begin
            pres_r <= 4'h0;
        end else if (rise) begin
            if (cap_evt) begin
                pres_r <= 4'h0;
            end else begin
                pres_r <= pres_r + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // time base selection
    // ------------------------------------------------------------
    always_comb begin
        if (ctrl_r.wide32) begin
            cap_value = {second_time_base_in, first_time_base_in};
        end else if (ctrl_r.src_second) begin
            cap_value = {16'h0000, second_time_base_in};
        end else begin
            cap_value = {16'h0000, first_time_base_in};
        end
    end

    // ------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------
    assign rd_take  = s_axi_arvalid_in && s_axi_arready_out;
    assign pop      = rd_take && s_axi_araddr_in == etc_pkg::ADDR_RESULT && count_r != 3'h0;
    // a full buffer drops the new capture unless a read frees a slot now
    assign push     = cap_evt && (count_r != etc_pkg::FIFO_FULL || pop);
    assign ovfl_evt = cap_evt && !push;
    assign count_nxt = count_r + {2'h0, push} - {2'h0, pop};

    always_ff @(posedge clock_in) begin
        if (push) begin
            fifo_mem[wr_ptr_r] <= cap_value;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_r <= 2'h0;
            rd_ptr_r <= 2'h0;
            count_r  <= 3'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 2'h1;
            end
            count_r <= count_nxt;
        end
    end

    // overflow stays until software turns the channel off
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ovfl_r <= 1'b0;
        end else if (ovfl_evt) begin
            ovfl_r <= 1'b1;
        end else if (!ctrl_r.enable) begin
            ovfl_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask and outputs
    // ------------------------------------------------------------
    assign fill_level = {1'b0, ctrl_r.fill_sel} + 3'h1;

    always_comb begin
        int_set = '0;
        int_set[etc_pkg::INT_FILL] = count_nxt >= fill_level && count_r < fill_level;
        int_set[etc_pkg::INT_CAPT] = cap_evt;
        int_set[etc_pkg::INT_OVFL] = ovfl_evt;
    end

    // a set in the same cycle as a write-one clear wins
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            int_stat_r <= etc_pkg::INT_RESET;
        end else if (wr_do && aw_addr_r == etc_pkg::ADDR_INT_STAT && w_strb_r[0]) begin
            int_stat_r <= (int_stat_r & ~w_data_r[etc_pkg::INT_W-1:0]) | int_set;
        end else begin
            int_stat_r <= int_stat_r | int_set;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_out       <= 1'b0;
            wake_out      <= 1'b0;
            ext_event_out <= 1'b0;
        end else begin
            irq_out       <= |((int_stat_r | int_set) & int_mask_r);
            wake_out      <= cap_evt && cpu_low_power_in;
            ext_event_out <= cap_evt;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h00000000;
        case (s_axi_araddr_in)
            etc_pkg::ADDR_CTRL: rd_word[etc_pkg::CTRL_W-1:0] = ctrl_r;
            etc_pkg::ADDR_STATUS: begin
                rd_word[etc_pkg::STAT_NEMPTY] = count_r != 3'h0;
                rd_word[etc_pkg::STAT_OVFL]   = ovfl_r;
                rd_word[etc_pkg::STAT_CNT_LO +: 3] = count_r;
            end
            etc_pkg::ADDR_RESULT: begin
                if (count_r != 3'h0) begin
                    rd_word = fifo_mem[rd_ptr_r];
                end
            end
            etc_pkg::ADDR_INT_STAT: rd_word[etc_pkg::INT_W-1:0] = int_stat_r;
            etc_pkg::ADDR_INT_MASK: rd_word[etc_pkg::INT_W-1:0] = int_mask_r;
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h00000000;
            s_axi_rresp_out   <= etc_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_word;
            case (s_axi_araddr_in)
                etc_pkg::ADDR_CTRL, etc_pkg::ADDR_STATUS, etc_pkg::ADDR_RESULT,
                etc_pkg::ADDR_INT_STAT, etc_pkg::ADDR_INT_MASK: begin
                    s_axi_rresp_out <= etc_pkg::RESP_OKAY;
                end
                default: begin
                    s_axi_rresp_out <= etc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

endmodule

// ---- dv/etc_properties.sv ----
`timescale 1ns/1ps

module etc_properties (
    input wire logic        clock_in,
    input wire logic        rst_b_in,
    input wire logic        capture_input_pin_in,
    input wire logic        cpu_low_power_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0]  s_axi_rresp_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic        wake_out,
    input wire logic        ext_event_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    // ------------------------------
    // cycles since the pin last moved, saturating
    // ------------------------------
    logic       pin_last_r;
    logic [2:0] since_chg_r;
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_last_r  <= 1'b0;
            since_chg_r <= 3'h7;
        end else begin
            pin_last_r <= capture_input_pin_in;
            if (capture_input_pin_in != pin_last_r) begin
                since_chg_r <= 3'h0;
            end else if (since_chg_r != 3'h7) begin
                since_chg_r <= since_chg_r + 3'h1;
            end
        end
    end

    // ------------------------------
    // bus handshakes
    // ------------------------------
    sequence s_wr_both;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_ar_take;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence

    a_write_answer: assert property (s_wr_both |-> ##[1:3] s_axi_bvalid_out)
        else $error("bvalid late");
    a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("bvalid dropped");
    a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)
        && $stable(s_axi_rresp_out)) else $error("rvalid dropped");
    a_read_answer: assert property (s_ar_take |=> s_axi_rvalid_out)
        else $error("rvalid late");
    a_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("arready while busy");
    a_aw_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("awready while busy");
    a_resp_legal: assert property (s_axi_bvalid_out |-> s_axi_bresp_out inside {2'h0, 2'h2})
        else $error("bad bresp");

    // ------------------------------
    // capture events
    // ------------------------------
    a_event_pulse: assert property (ext_event_out |=> !ext_event_out)
        else $error("event pulse too long");
    a_event_cause: assert property (ext_event_out |-> since_chg_r >= 3'h1 && since_chg_r <= 3'h5)
        else $error("event without pin edge");
    a_wake_cause: assert property (wake_out |-> ext_event_out && $past(cpu_low_power_in))
        else $error("wake without cause");
endmodule

bind etc_top etc_properties etc_properties_inst (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .capture_input_pin_in(capture_input_pin_in),
    .cpu_low_power_in(cpu_low_power_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
    .wake_out(wake_out), .ext_event_out(ext_event_out)
);

// ---- dv/etc_pulse_src.sv ----
`timescale 1ns/1ps

module etc_pulse_src (
    input  wire logic clock_in,
    output logic      pin_out
);
    initial pin_out = 1'b0;

    // one level change, held long enough for the synchroniser
    task automatic toggle();
        @(posedge clock_in);
        pin_out <= ~pin_out;
        repeat (6) @(posedge clock_in);
    endtask
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
    typedef struct packed {
        logic [2:0] mode;
        logic       fr;
        logic       sec;
        logic       w32;
        logic [5:0] n;
    } etc_case_type;

    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        pin;
    logic [15:0] first_base = 16'h0000;
    logic [15:0] second_base = 16'h0000;
    logic        lp = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, wake, evt;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          miscompares = 0;
    int          comparisons = 0;
    int          evt_cnt = 0;
    int          wake_cnt = 0;

    always #12.5 clock_in = ~clock_in;

    always @(posedge clock_in) begin
        evt_cnt += evt;
        wake_cnt += wake;
    end

    etc_top etc_top_inst (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .capture_input_pin_in(pin),
        .first_time_base_in(first_base), .second_time_base_in(second_base), .cpu_low_power_in(lp),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .irq_out(irq), .wake_out(wake), .ext_event_out(evt));

    etc_pulse_src etc_pulse_src_inst (.clock_in(clock_in), .pin_out(pin));

    // ------------------------------
    // bus tasks
    // ------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // past the last register: error response
    function automatic logic [31:0] resp_for(input logic [7:0] a);
        return (a > etc_pkg::ADDR_INT_MASK) ? {30'h0, etc_pkg::RESP_SLVERR} : {30'h0, etc_pkg::RESP_OKAY};
    endfunction

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, resp_for(a));
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock_in);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        check(what, rdata, e);
        check("rresp", {30'h0, rresp}, resp_for(a));
    endtask

    task automatic edge_go(input logic [15:0] k);
        first_base <= 16'h1000 + k;
        second_base <= 16'hA000 + k;
        etc_pulse_src_inst.toggle();
    endtask

    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------
    // tests
    // ------------------------------
    etc_case_type cases [8] = '{
        '{etc_pkg::MODE_FALL, 1'b0, 1'b0, 1'b0, 6'd6}, '{etc_pkg::MODE_RISE, 1'b0, 1'b1, 1'b0, 6'd6},
        '{etc_pkg::MODE_BOTH, 1'b0, 1'b0, 1'b1, 6'd6}, '{etc_pkg::MODE_FIRST, 1'b0, 1'b0, 1'b0, 6'd6},
        '{etc_pkg::MODE_FIRST, 1'b1, 1'b0, 1'b0, 6'd6}, '{etc_pkg::MODE_DIV4, 1'b0, 1'b0, 1'b0, 6'd16},
        '{etc_pkg::MODE_DIV16, 1'b0, 1'b0, 1'b0, 6'd34}, '{etc_pkg::MODE_OFF, 1'b0, 1'b0, 1'b0, 6'd2}};

    initial begin
        etc_case_type tc;
        logic         rising, armed, cap;
        logic [15:0]  kk;
        logic [31:0]  ev;
        int           rises, ec, wc;
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        for (int a = 0; a <= 20; a += 4) rd_chk($sformatf("reset %0h", a), 8'(a), 32'h0);
        axi_wr(8'h14, 32'hFFFFFFFF);
        axi_wr(etc_pkg::ADDR_STATUS, 32'hFFFFFFFF);
        rd_chk("empty pop", etc_pkg::ADDR_RESULT, 32'h0);
        axi_wr(etc_pkg::ADDR_CTRL, 32'hFFFFFFFF);
        rd_chk("ctrl rw", etc_pkg::ADDR_CTRL, 32'h000001FF);
        for (int i = 0; i < 8; i++) begin
            tc = cases[i];
            lp <= i[0];
            axi_wr(etc_pkg::ADDR_CTRL, {23'h0, 1'b1, 2'h0, tc.w32, tc.sec, tc.fr, tc.mode});
            armed = (tc.mode == etc_pkg::MODE_BOTH);
            rises = 0;
            for (int k = 1; k <= tc.n; k++) begin
                kk = k[15:0];
                rising = !pin;
                ec = evt_cnt;
                wc = wake_cnt;
                edge_go(kk);
                rises += rising;
                if (tc.mode == etc_pkg::MODE_FIRST && rising == tc.fr) armed = 1'b1;
                case (tc.mode)
                    etc_pkg::MODE_FALL: cap = !rising;
                    etc_pkg::MODE_RISE: cap = rising;
                    etc_pkg::MODE_DIV4: cap = rising && (rises % 4 == 0);
                    etc_pkg::MODE_DIV16: cap = rising && (rises % 16 == 0);
                    default: cap = armed;
                endcase
                ev = tc.w32 ? {16'hA000 + kk, 16'h1000 + kk} : {16'h0, tc.sec ? 16'hA000 + kk : 16'h1000 + kk};
                check("events", evt_cnt - ec, {31'h0, cap});
                check("wakes", wake_cnt - wc, {31'h0, cap && lp});
                rd_chk("count", etc_pkg::ADDR_STATUS, cap ? 32'h5 : 32'h0);
                if (cap) rd_chk("result", etc_pkg::ADDR_RESULT, ev);
            end
        end
        axi_wr(etc_pkg::ADDR_INT_STAT, 32'h7);
        axi_wr(etc_pkg::ADDR_INT_MASK, 32'h1);
        for (int lvl = 1; lvl <= 4; lvl++) begin
            axi_wr(etc_pkg::ADDR_CTRL, {23'h0, 1'b1, 2'(lvl - 1), 3'h0, etc_pkg::MODE_RISE});
            for (int k = 1; k <= lvl + lvl / 4; k++) begin
                edge_go(k[15:0]);
                edge_go(16'h0);
                check("irq", {31'h0, irq}, {31'h0, k >= lvl});
            end
            rd_chk("int stat", etc_pkg::ADDR_INT_STAT, lvl == 4 ? 32'h7 : 32'h3);
            rd_chk("full", etc_pkg::ADDR_STATUS, {27'h0, 3'(lvl), lvl == 4, 1'b1});
            axi_wr(etc_pkg::ADDR_INT_STAT, 32'h7);
            rd_chk("int clear", etc_pkg::ADDR_INT_STAT, 32'h0);
            check("irq clear", {31'h0, irq}, 32'h0);
            for (int k = 1; k <= lvl; k++) rd_chk("fifo", etc_pkg::ADDR_RESULT, 32'h1000 + k);
            rd_chk("drained", etc_pkg::ADDR_STATUS, {30'h0, lvl == 4, 1'b0});
            axi_wr(etc_pkg::ADDR_CTRL, 32'h0);
        end
        finish_test();
    end

    initial begin
        #1000000;
        miscompares++;
        finish_test();
    end
endmodule
